// ===== cefb_regs.vh
// Notes on behaviour
// - Detection-done bit six set when detection finishes.
// - Conversion-done bit five set, one-shot mode only.
// - Bit four set entering or leaving minimum regulation.
// - Timer expiry rising edges set bits three to zero.
// - Boost-too-low sets bit four; bits seven-five zero.
// - Thermistor threshold crossings set bits three to zero.
// - All flags and mask reset to zero.
// - Battery-current regulation begin or end sets bit seven.
// - Each protection entry sets its fault bit.
// - System short and overvoltage stops set bits seven, six.
// - Boost output over/undervoltage stops set bits five, four.
// - Thermal shutdown rise sets bit two; others reserved.
// - Mask register: eight read-write bits, reset zero.
// - Mask bit one suppresses that event's pulse.
`ifndef CEFB_REGS_VH
`define CEFB_REGS_VH

// ****************************************************************
// Register indices (word addresses on the slave port)
// ****************************************************************
`define CEFB_IDX_CHG_FLAGS_2 6'h24
`define CEFB_IDX_CHG_FLAGS_3 6'h25
`define CEFB_IDX_FLT_FLAGS_0 6'h26
`define CEFB_IDX_FLT_FLAGS_1 6'h27
`define CEFB_IDX_CHG_MASK_0 6'h28
`define CEFB_IDX_IRQ_STATUS 6'h30
`define CEFB_IDX_IRQ_MASK 6'h31

// ****************************************************************
// Reset values and implemented bits
// ****************************************************************
`define CEFB_FLAGS_RESET 32'h00000000
`define CEFB_MASK_RESET 8'h00
`define CEFB_IRQ_RESET 5'h00
`define CEFB_VALID_BITS 32'hF4FF1F7F
`define CEFB_RISE_BITS 32'hF4FF1F7F
`define CEFB_FALL_BITS 32'h00800F10

// ****************************************************************
// Interrupt status bit positions
// ****************************************************************
`define CEFB_IRQ_BIT_CHG2 0
`define CEFB_IRQ_BIT_CHG3 1
`define CEFB_IRQ_BIT_FLT0 2
`define CEFB_IRQ_BIT_FLT1 3
`define CEFB_IRQ_BIT_PRIM 4
`define CEFB_IRQ_WIDTH 5

`endif

// ===== cefb_top.v
`timescale 1ns/1ps
`default_nettype none
`include "cefb_regs.vh"

module cefb_top (
  // Clock, reset and clock enable.
  input wire ref_clk,
  input wire rstn,
  input wire ce,
  // Avalon-MM slave.
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Charger event sources, levels.
  input wire dataline_detect_complete,
  input wire adc_conversion_done,
  input wire adc_one_shot_mode,
  input wire min_system_regulation_active,
  input wire fast_charge_expiry,
  input wire trickle_expiry,
  input wire precharge_expiry,
  input wire topoff_expiry,
  input wire battery_too_low_for_boost,
  input wire thermistor_cold_cross,
  input wire thermistor_cool_cross,
  input wire thermistor_warm_cross,
  input wire thermistor_hot_cross,
  // Fault event sources, levels.
  input wire battery_current_regulation_active,
  input wire bus_overvoltage_active,
  input wire battery_overvoltage_active,
  input wire bus_overcurrent_active,
  input wire discharge_overcurrent_active,
  input wire converter_overcurrent_active,
  input wire input2_overvoltage_active,
  input wire input1_overvoltage_active,
  input wire system_short_stop,
  input wire system_overvoltage_stop,
  input wire boost_output_overvoltage_stop,
  input wire boost_output_undervoltage_stop,
  input wire die_thermal_shutdown,
  // One-cycle pulses of the events gated by the charger mask register.
  input wire [7:0] charger_status_events,
  // Interrupt outputs.
  output reg irq,
  output reg int_pulse
);

  reg rst_meta_ff;
  reg rst_sync_ff;
  reg primed_ff;
  reg [31:0] prev_lvl_ff;
  reg [31:0] flags_ff;
  reg [7:0] mask_ff;
  reg [`CEFB_IRQ_WIDTH-1:0] irq_status_ff;
  reg [`CEFB_IRQ_WIDTH-1:0] irq_mask_ff;

  reg [31:0] lvl;
  reg [31:0] ev;
  reg [31:0] rd_clr;
  reg [31:0] nxt_flags;
  reg [7:0] nxt_mask;
  reg [7:0] prim_ev;
  reg [`CEFB_IRQ_WIDTH-1:0] irq_ev;
  reg [`CEFB_IRQ_WIDTH-1:0] nxt_irq_status;
  reg [`CEFB_IRQ_WIDTH-1:0] nxt_irq_mask;
  reg [31:0] nxt_readdata;
  reg access;
  reg do_read;
  reg do_write;
  reg wr_lane0;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ****************************************************************
  // Event detection and register next state
  // ****************************************************************
  always @* begin
    lvl = {system_short_stop, system_overvoltage_stop, boost_output_overvoltage_stop,
           boost_output_undervoltage_stop, 1'b0, die_thermal_shutdown, 2'b00,
           battery_current_regulation_active, bus_overvoltage_active, battery_overvoltage_active,
           bus_overcurrent_active, discharge_overcurrent_active, converter_overcurrent_active,
           input2_overvoltage_active, input1_overvoltage_active,
           3'b000, battery_too_low_for_boost, thermistor_cold_cross, thermistor_cool_cross,
           thermistor_warm_cross, thermistor_hot_cross,
           1'b0, dataline_detect_complete, adc_conversion_done & adc_one_shot_mode,
           min_system_regulation_active, fast_charge_expiry, trickle_expiry,
           precharge_expiry, topoff_expiry};
    // Edge selection per bit: rising for entries, both for regulation and zone changes.
    ev = ((lvl & ~prev_lvl_ff & `CEFB_RISE_BITS) | (~lvl & prev_lvl_ff & `CEFB_FALL_BITS))
         & `CEFB_VALID_BITS;
    // The first cycle after reset only learns the levels, so a source already high is not an event.
    if (!primed_ff) begin
      ev = 32'h00000000;
    end

    access = avs_waitrequest & (avs_read | avs_write);
    do_read = access & avs_read;
    do_write = access & avs_write & ~avs_read;
    wr_lane0 = do_write & avs_byteenable[0];

    rd_clr = 32'h00000000;
    nxt_readdata = 32'h00000000;
    nxt_mask = mask_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_irq_status = irq_status_ff;
    case (avs_address)
      `CEFB_IDX_CHG_FLAGS_2: begin
        nxt_readdata = {24'h000000, flags_ff[7:0]};
        rd_clr[7:0] = {8{do_read}};
      end
      `CEFB_IDX_CHG_FLAGS_3: begin
        nxt_readdata = {24'h000000, flags_ff[15:8]};
        rd_clr[15:8] = {8{do_read}};
      end
      `CEFB_IDX_FLT_FLAGS_0: begin
        nxt_readdata = {24'h000000, flags_ff[23:16]};
        rd_clr[23:16] = {8{do_read}};
      end
      `CEFB_IDX_FLT_FLAGS_1: begin
        nxt_readdata = {24'h000000, flags_ff[31:24]};
        rd_clr[31:24] = {8{do_read}};
      end
      `CEFB_IDX_CHG_MASK_0: begin
        nxt_readdata = {24'h000000, mask_ff};
        if (wr_lane0) begin
          nxt_mask = avs_writedata[7:0];
        end
      end
      `CEFB_IDX_IRQ_STATUS: begin
        nxt_readdata = {27'h0000000, irq_status_ff};
        if (wr_lane0) begin
          nxt_irq_status = irq_status_ff & ~avs_writedata[`CEFB_IRQ_WIDTH-1:0];
        end
      end
      `CEFB_IDX_IRQ_MASK: begin
        nxt_readdata = {27'h0000000, irq_mask_ff};
        if (wr_lane0) begin
          nxt_irq_mask = avs_writedata[`CEFB_IRQ_WIDTH-1:0];
        end
      end
      default: begin
        nxt_readdata = 32'h00000000;
      end
    endcase

    // A new event wins over the read that clears its register in the same cycle.
    nxt_flags = (flags_ff & ~rd_clr) | ev;

    prim_ev = charger_status_events & ~mask_ff;
    irq_ev[`CEFB_IRQ_BIT_CHG2] = |ev[7:0];
    irq_ev[`CEFB_IRQ_BIT_CHG3] = |ev[15:8];
    irq_ev[`CEFB_IRQ_BIT_FLT0] = |ev[23:16];
    irq_ev[`CEFB_IRQ_BIT_FLT1] = |ev[31:24];
    irq_ev[`CEFB_IRQ_BIT_PRIM] = |prim_ev;
    // Set wins over a write-one-to-clear in the same cycle.
    nxt_irq_status = nxt_irq_status | irq_ev;
  end

  // ****************************************************************
  // State
  // ****************************************************************
  always @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      primed_ff <= 1'b0;
      prev_lvl_ff <= 32'h00000000;
      flags_ff <= `CEFB_FLAGS_RESET;
      mask_ff <= `CEFB_MASK_RESET;
      irq_status_ff <= `CEFB_IRQ_RESET;
      irq_mask_ff <= `CEFB_IRQ_RESET;
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
      irq <= 1'b0;
      int_pulse <= 1'b0;
    end else if (ce) begin
      primed_ff <= 1'b1;
      prev_lvl_ff <= lvl;
      flags_ff <= nxt_flags;
      mask_ff <= nxt_mask;
      irq_status_ff <= nxt_irq_status;
      irq_mask_ff <= nxt_irq_mask;
      // Waitrequest drops for exactly one cycle per access; the cycle after it
      // ignores the still-held request so nothing is applied twice.
      if (access) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= nxt_readdata;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      irq <= |(nxt_irq_status & ~nxt_irq_mask);
      int_pulse <= (|(ev & ~flags_ff)) | (|prim_ev);
    end
  end

endmodule
`default_nettype wire

// ===== cefb_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cefb_chk (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Watched ports.
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic topoff_expiry,
  input wire logic int_pulse
);
  // ********
  // Bus cycle shapes
  // ********
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_rd;
    avs_read && !avs_waitrequest;
  endsequence
  a_answer_next: assert property (s_req |=> !avs_waitrequest) else $error("no answer");
  a_no_spurious: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("spurious answer");
  a_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest) else $error("long answer");
  a_upper_zero: assert property (s_rd |-> avs_readdata[31:8] == 24'h0) else $error("upper bits set");
  a_unmapped_zero: assert property (s_rd and avs_address == 6'h3F |-> avs_readdata == 32'h0)
    else $error("unmapped not zero");
  a_reserved_chg: assert property (s_rd and avs_address == 6'h25 |-> avs_readdata[7:5] == 3'h0)
    else $error("reserved set");
  a_reserved_flt: assert property (s_rd and avs_address == 6'h27 |-> avs_readdata[3] == 1'b0 && avs_readdata[1:0] == 2'h0)
    else $error("reserved set");
  a_expiry_pulse: assert property ($rose(topoff_expiry) |=> int_pulse) else $error("no pulse");
endmodule
bind cefb_top cefb_chk u_chk (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .topoff_expiry, .int_pulse);
`default_nettype wire

// ===== cefb_host.sv
`timescale 1ns/1ps
`default_nettype none
module cefb_host (
  // Clock.
  input wire logic ref_clk,
  // Avalon-MM master.
  output logic [5:0] avs_address = 6'h0,
  output logic avs_read = 1'b0,
  output logic avs_write = 1'b0,
  output logic [31:0] avs_writedata = 32'h0,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // The request is held until waitrequest is seen low, so any answer time is safe.
  task xfer(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    do @(posedge ref_clk); while (avs_waitrequest);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cefb_regs.vh"
module testbench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic mode = 1'b0;
  logic hit = 1'b0;
  logic [31:0] ev = 32'h0;
  logic [31:0] vb = `CEFB_VALID_BITS;
  logic [7:0] cse = 8'h0;
  logic [7:0] q;
  logic [15:0] r = 16'h2C0A;
  int n_fail = 0;
  int n_tests = 0;
  int np = 0;
  int b;
  wire [5:0] a;
  wire rd, wr, wq, irq, ip;
  wire [31:0] wd, rdat;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) np <= np + ip;
  cefb_host host (.ref_clk, .avs_address(a), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wq));
  cefb_top dut (.ref_clk, .rstn, .ce(1'b1), .avs_address(a), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wq),
    .dataline_detect_complete(ev[6]), .adc_conversion_done(ev[5]), .adc_one_shot_mode(mode),
    .min_system_regulation_active(ev[4]), .fast_charge_expiry(ev[3]), .trickle_expiry(ev[2]),
    .precharge_expiry(ev[1]), .topoff_expiry(ev[0]), .battery_too_low_for_boost(ev[12]),
    .thermistor_cold_cross(ev[11]), .thermistor_cool_cross(ev[10]), .thermistor_warm_cross(ev[9]),
    .thermistor_hot_cross(ev[8]), .battery_current_regulation_active(ev[23]), .bus_overvoltage_active(ev[22]),
    .battery_overvoltage_active(ev[21]), .bus_overcurrent_active(ev[20]), .discharge_overcurrent_active(ev[19]),
    .converter_overcurrent_active(ev[18]), .input2_overvoltage_active(ev[17]), .input1_overvoltage_active(ev[16]),
    .system_short_stop(ev[31]), .system_overvoltage_stop(ev[30]), .boost_output_overvoltage_stop(ev[29]),
    .boost_output_undervoltage_stop(ev[28]), .die_thermal_shutdown(ev[26]), .charger_status_events(cse),
    .irq, .int_pulse(ip));
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Flag byte expected after a rise (p high) or a fall of event line i.
  function automatic logic [7:0] fx(input int i, input logic p);
    logic [31:0] fb;
    fb = p ? `CEFB_RISE_BITS : `CEFB_FALL_BITS;
    return (fb[i] && (i != 5 || mode || !p)) ? 8'h01 << i[2:0] : 8'h00;
  endfunction
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task rdc(input logic [5:0] ad, input logic [7:0] e);
    host.xfer(1'b0, ad, 8'h00, q);
    chk($sformatf("reg %h", ad), e, q);
  endtask
  task test_done;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ********
  // Main sequence
  // ********
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int k = 0; k < 5; k++) rdc(6'h24 + k[5:0], 8'h00);
    rdc(6'h3F, 8'h00);
    for (int i = 0; i < 32; i++) begin
      if (!vb[i]) continue;
      r = nx(r);
      mode <= r[0];
      for (int p = 1; p >= 0; p--) begin
        b = np;
        ev[i] <= p[0];
        repeat (3) @(posedge ref_clk);
        rdc(6'h24 + i[4:3], fx(i, p[0]));
        rdc(6'h24 + i[4:3], 8'h00);
        chk("pulses", {7'h0, |fx(i, p[0])}, 8'(np - b));
      end
    end
    // A mask gates the pulse and interrupt status bit four, so each round checks both the readback and the pulse.
    repeat (8) begin
      r = nx(r);
      host.xfer(1'b1, 6'h28, r[7:0], q);
      rdc(6'h28, r[7:0]);
      b = np;
      cse <= r[15:8];
      @(posedge ref_clk);
      cse <= 8'h00;
      repeat (3) @(posedge ref_clk);
      hit = hit | (|(r[15:8] & ~r[7:0]));
      chk("status pulse", {7'h0, |(r[15:8] & ~r[7:0])}, 8'(np - b));
    end
    chk("irq", {7'h0, irq}, 8'h01);
    rdc(6'h30, {3'h0, hit, 4'hF});
    host.xfer(1'b1, 6'h31, 8'h1F, q);
    repeat (2) @(posedge ref_clk);
    chk("irq masked", {7'h0, irq}, 8'h00);
    host.xfer(1'b1, 6'h30, 8'h1F, q);
    host.xfer(1'b1, 6'h31, 8'h00, q);
    rdc(6'h30, 8'h00);
    chk("irq cleared", {7'h0, irq}, 8'h00);
    test_done;
  end
  initial begin
    #100000;
    n_fail++;
    test_done;
  end
endmodule
`default_nettype wire
